// *** mst_host_model.sv ***
// host model driving the step and direction pins
// assumes each pin level is held well over two clocks
`timescale 1ns/100ps
`default_nettype none
module mst_host_model (
  // clock
  input  wire logic clk_i,
  // pins
  output logic      step_o,
  output logic      dir_o
);
  initial begin
    step_o = 1'b0;
    dir_o = 1'b0;
  end
  // direction settles a cycle ahead of the edge; long levels keep spacing
  task drive(input logic v, input logic d);
    @(posedge clk_i);
    dir_o <= d;
    @(posedge clk_i);
    step_o <= v;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// *** mst_map.vh ***
// mst_map.vh: register map, field layout, mode codes and step sizes
// for the micro-step translator; definitions only, no logic.
`ifndef MST_MAP_VH
`define MST_MAP_VH

// apb register byte offsets
`define MST_ADDR_W          8
`define MST_OFF_CTRL        8'h00
`define MST_OFF_STATUS      8'h04
`define MST_OFF_COIL        8'h08

// control register fields
`define MST_CTRL_SEL_HI     2
`define MST_CTRL_SEL_LO     0
`define MST_CTRL_INV_BIT    3
`define MST_CTRL_POL_BIT    4

// coil readback register fields
`define MST_COIL_X_HI       10
`define MST_COIL_X_LO       0
`define MST_COIL_Y_HI       26
`define MST_COIL_Y_LO       16

// resolution select codes
`define MST_SEL_32          3'h0
`define MST_SEL_16          3'h1
`define MST_SEL_8           3'h2
`define MST_SEL_4           3'h3
`define MST_SEL_2           3'h4
`define MST_SEL_HALF_SQ     3'h5
`define MST_SEL_FULL        3'h6

// step size in 1/32 units for each resolution
`define MST_STEP_32         7'h01
`define MST_STEP_16         7'h02
`define MST_STEP_8          7'h04
`define MST_STEP_4          7'h08
`define MST_STEP_2          7'h10
`define MST_STEP_FULL       7'h20

// reset values
`define MST_RST_POS         7'h00
`define MST_RST_SEL         3'h0
`define MST_RST_COIL        11'h000

// quarter-wave table span, and current scale in tenths of a percent
`define MST_QUARTER         6'h20
`define MST_FULL_SCALE      10'h3E8
`define MST_ZERO_MAG        10'h000

`endif

// *** mst_sine_rom.v ***
// mst_sine_rom.v: quarter-wave current table, two read ports.
// assumes the caller delays its own side data by one cycle to match.
`timescale 1ns/100ps
`default_nettype none

module mst_sine_rom (
  // clock
  input  wire       clk_i,
  // read addresses, 0 to 32
  input  wire [5:0] addr_a_i,
  input  wire [5:0] addr_b_i,
  // registered magnitudes in tenths of a percent
  output reg  [9:0] data_a_o,
  output reg  [9:0] data_b_o
);

  function [9:0] lut;
    input [5:0] a;
    begin
      case (a)
        6'h00: lut = 10'd0;
        6'h01: lut = 10'd35;
        6'h02: lut = 10'd81;
        6'h03: lut = 10'd127;
        6'h04: lut = 10'd174;
        6'h05: lut = 10'd221;
        6'h06: lut = 10'd267;
        6'h07: lut = 10'd314;
        6'h08: lut = 10'd349;
        6'h09: lut = 10'd383;
        6'h0A: lut = 10'd430;
        6'h0B: lut = 10'd465;
        6'h0C: lut = 10'd500;
        6'h0D: lut = 10'd546;
        6'h0E: lut = 10'd581;
        6'h0F: lut = 10'd616;
        6'h10: lut = 10'd651;
        6'h11: lut = 10'd686;
        6'h12: lut = 10'd721;
        6'h13: lut = 10'd755;
        6'h14: lut = 10'd790;
        6'h15: lut = 10'd826;
        6'h16: lut = 10'd849;
        6'h17: lut = 10'd872;
        6'h18: lut = 10'd895;
        6'h19: lut = 10'd918;
        6'h1A: lut = 10'd930;
        6'h1B: lut = 10'd941;
        6'h1C: lut = 10'd953;
        6'h1D: lut = 10'd965;
        6'h1E: lut = 10'd977;
        6'h1F: lut = 10'd988;
        6'h20: lut = 10'd1000;
        default: lut = 10'd0;
      endcase
    end
  endfunction

  // registered read keeps the table off the output timing path
  always @(posedge clk_i) begin
    data_a_o <= lut(addr_a_i);
    data_b_o <= lut(addr_b_i);
  end

endmodule

`default_nettype wire

// *** mst_tb.sv ***
// self-checking bench for the micro-step translator
// assumes the host model drives the pins; monitor bound below
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  wire  [31:0] prdata_o;
  wire         pready_o;
  wire         pslverr_o;
  wire         step_pulse_in_i;
  wire         dir_i;
  wire  [6:0]  microstep_position_o;
  wire  [2:0]  active_resolution_o;
  wire         step_trigger_o;
  wire  [10:0] coil_x_o;
  wire  [10:0] coil_y_o;
  logic [31:0] r;
  logic        e;
  int          fails = 0;
  int          samples_checked = 0;
  always #20 clk_i = ~clk_i;
  mst_translator u_dut (.*);
  mst_host_model u_host (.clk_i(clk_i), .step_o(step_pulse_in_i), .dir_o(dir_i));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, g, x);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    cmp(r, x);
  endtask
  task pls(input logic d, input logic [6:0] x);
    u_host.drive(1'b1, d);
    u_host.drive(1'b0, d);
    rd(8'h04, {25'h0, x});
  endtask
  task t_reset;
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h03E8_0000);
    $display("test reset done");
  endtask
  task t_edge;
    u_host.drive(1'b1, 1'b1);
    rd(8'h04, 32'h0000_0001);
    u_host.drive(1'b0, 1'b1);
    rd(8'h04, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0010);
    u_host.drive(1'b1, 1'b1);
    rd(8'h04, 32'h0000_0001);
    u_host.drive(1'b0, 1'b1);
    rd(8'h04, 32'h0000_0002);
    apb(1'b1, 8'h00, 32'h0000_0000);
    $display("test edge done");
  endtask
  task t_dir;
    pls(1'b0, 7'h01);
    apb(1'b1, 8'h00, 32'h0000_0008);
    pls(1'b0, 7'h02);
    pls(1'b1, 7'h01);
    apb(1'b1, 8'h00, 32'h0000_0000);
    pls(1'b0, 7'h00);
    pls(1'b0, 7'h7F);
    pls(1'b1, 7'h00);
    $display("test direction done");
  endtask
  task t_modes;
    logic [6:0] s;
    for (int k = 0; k < 7; k++) begin
      s = (k == 5) ? 7'h10 : (k == 6) ? 7'h20 : 7'h01 << k;
      apb(1'b1, 8'h00, 32'(k));
      cmp({29'h0, active_resolution_o}, 32'((k == 0) ? 0 : k - 1));
      pls(1'b1, s);
      cmp({29'h0, active_resolution_o}, 32'(k));
      pls(1'b0, 7'h00);
    end
    apb(1'b1, 8'h00, 32'h0000_0000);
    pls(1'b1, 7'h01);
    pls(1'b0, 7'h00);
    $display("test modes done");
  endtask
  task t_grid;
    pls(1'b1, 7'h01);
    apb(1'b1, 8'h00, 32'h0000_0003);
    pls(1'b1, 7'h09);
    apb(1'b1, 8'h00, 32'h0000_0000);
    pls(1'b1, 7'h0A);
    apb(1'b1, 8'h00, 32'h0000_0001);
    pls(1'b1, 7'h0C);
    apb(1'b1, 8'h00, 32'h0000_0002);
    pls(1'b1, 7'h10);
    apb(1'b1, 8'h00, 32'h0000_0004);
    pls(1'b1, 7'h20);
    pls(1'b1, 7'h30);
    pls(1'b1, 7'h40);
    rd(8'h08, 32'h0418_0000);
    pls(1'b1, 7'h50);
    pls(1'b1, 7'h60);
    rd(8'h08, 32'h0000_0418);
    apb(1'b1, 8'h00, 32'h0000_0005);
    pls(1'b0, 7'h50);
    rd(8'h08, 32'h0418_0418);
    $display("test grid done");
  endtask
  task t_bus;
    rd(8'h0C, 32'h0000_0000);
    cmp({31'h0, e}, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_007F);
    rd(8'h04, 32'h0000_0050);
    apb(1'b1, 8'h00, 32'hFFFF_FFE5);
    rd(8'h00, 32'h0000_0005);
    apb(1'b1, 8'h00, 32'h0000_0007);
    pls(1'b1, 7'h51);
    cmp({29'h0, active_resolution_o}, 32'h0000_0007);
    apb(1'b1, 8'h00, 32'h0000_0000);
    $display("test bus done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_edge;
    t_dir;
    t_modes;
    t_grid;
    t_bus;
    complete_run;
  end
  // the whole run needs about a tenth of this span
  initial begin
    #400_000;
    fails++;
    complete_run;
  end
endmodule
bind mst_translator mst_tb_monitor u_mon (.*);
`default_nettype wire

// *** mst_tb_monitor.sv ***
// port checker for the micro-step translator
// assumes it is bound to mst_translator; one clock domain
`timescale 1ns/100ps
`default_nettype none
module mst_tb_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // translator
  input wire logic [6:0]  microstep_position_o,
  input wire logic [2:0]  active_resolution_o,
  input wire logic        step_trigger_o,
  input wire logic [10:0] coil_x_o,
  input wire logic [10:0] coil_y_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] up_reg;
  function automatic logic [6:0] sz(input logic [2:0] m);
    sz = (m == 3'h5) ? 7'h10 : (m == 3'h6) ? 7'h20 : (m == 3'h7) ? 7'h01 : 7'h01 << m;
  endfunction
  // coil settling after reset would look like a spurious change
  always @(posedge clk_i) begin
    if (!rst_n_i) up_reg <= 3'h0;
    else if (up_reg != 3'h7) up_reg <= up_reg + 3'h1;
  end
  sequence s_step;
    step_trigger_o ##1 1'b1;
  endsequence
  sequence s_rest;
    up_reg == 3'h7 && $past(microstep_position_o, 4) == microstep_position_o
      && $past(active_resolution_o, 4) == active_resolution_o;
  endsequence
  property p_pt(logic [6:0] p, logic [10:0] x, logic [10:0] y);
    s_rest ##0 (microstep_position_o == p && active_resolution_o < 3'h5)
      |-> coil_x_o == x && coil_y_o == y;
  endproperty
  ready_high_a: assert property (pready_o)
    else $error("pready low");
  bad_addr_a: assert property (psel_i && penable_i
    |-> pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08}))
    else $error("pslverr wrong");
  pos_hold_a: assert property (!step_trigger_o |=> $stable(microstep_position_o))
    else $error("position moved without trigger");
  pos_step_a: assert property (s_step |->
    7'(microstep_position_o - $past(microstep_position_o))
      inside {sz(active_resolution_o), 7'(-sz(active_resolution_o))})
    else $error("position step size wrong");
  res_hold_a: assert property ($changed(active_resolution_o) |-> $past(step_trigger_o))
    else $error("resolution changed without trigger");
  trig_pulse_a: assert property (step_trigger_o |=> !step_trigger_o [*3])
    else $error("trigger too close");
  coil_follow_a: assert property (up_reg == 3'h7 &&
    ($changed(coil_x_o) || $changed(coil_y_o)) |->
      $past(microstep_position_o, 1) != $past(microstep_position_o, 4)
      || $past(active_resolution_o, 1) != $past(active_resolution_o, 4))
    else $error("coil changed without step");
  square_full_a: assert property (s_rest ##0 active_resolution_o == 3'h5 |->
    coil_x_o inside {11'h000, 11'h3E8, 11'h418} && coil_y_o inside {11'h000, 11'h3E8, 11'h418})
    else $error("square coil not full scale");
  full_square_a: assert property (s_rest ##0 active_resolution_o == 3'h6 |->
    coil_x_o inside {11'h000, 11'h3E8, 11'h418} && coil_y_o inside {11'h000, 11'h3E8, 11'h418})
    else $error("full step coil not full scale");
  pos_low_a: assert property (p_pt(7'h40, 11'h000, 11'h418))
    else $error("coil at 64 wrong");
  pos_left_a: assert property (p_pt(7'h60, 11'h418, 11'h000))
    else $error("coil at 96 wrong");
endmodule
`default_nettype wire

// *** mst_translator.v ***
// mst_translator.v: step translator with apb control and status.
// assumes step and direction pins are asynchronous to clk_i and that
// the apb master runs on clk_i.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "mst_map.vh"

// What this block does
// - only one step-input edge counts; polarity bit picks rising or falling
// - each step trigger moves position one step of current resolution
// - direction comes from the pin and the software invert bit together
// - position readback is 7 bits in 1/32 units in every mode
// - readback position changes right after each step trigger
// - a new resolution takes effect only at the next step trigger
// - finer resolution steps by its size from the present position, keeping any grid offset
// - coarser resolution on a shared position steps on the table grid
// - coarser resolution off grid keeps stepping with constant offset
// - position maps to signed x and y currents on a sine circle
// - coarse circular modes visit multiples of their step size plus any offset held from before
// - select codes 000 to 110 give the seven step modes
// - reset gives 1/32 mode at position zero
// - square modes drive every nonzero coil current at full scale
module mst_translator (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output reg         pslverr_o,
  // motor control pins
  input  wire        step_pulse_in_i,
  input  wire        dir_i,
  // translator state
  output wire [6:0]  microstep_position_o,
  output wire [2:0]  active_resolution_o,
  output wire        step_trigger_o,
  // coil setpoints, signed tenths of a percent of peak
  output reg  [10:0] coil_x_o,
  output reg  [10:0] coil_y_o
);

  // pin synchronisers
  reg  [1:0] sync1_reg;
  reg  [1:0] sync2_reg;
  reg        step_prev_reg;

  // software control
  reg  [2:0] sel_reg;
  reg        inv_reg;
  reg        pol_reg;

  // translator state
  reg  [6:0] pos_reg;
  reg  [6:0] pos_next;
  reg  [2:0] act_reg;
  reg  [6:0] step_size;

  // table pipeline
  wire [5:0] lo_addr;
  wire [5:0] hi_addr;
  wire [5:0] addr_x;
  wire [5:0] addr_y;
  wire [9:0] mag_x;
  wire [9:0] mag_y;
  reg        neg_x_reg;
  reg        neg_y_reg;
  reg        square_reg;
  reg  [9:0] out_x;
  reg  [9:0] out_y;

  // decode
  wire       step_sync;
  wire       dir_sync;
  wire       rise;
  wire       fall;
  wire       trigger;
  wire       dir_up;
  wire       setup;
  wire       wr_access;
  wire       hit_ctrl;
  wire       hit_status;
  wire       hit_coil;
  wire       hit_any;

  // two flip-flops per pin before any logic reads it
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= (g == 0) ? step_pulse_in_i : dir_i;
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign step_sync = sync2_reg[0];
  assign dir_sync  = sync2_reg[1];

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= step_sync;
    end
  end

  assign rise = step_sync & ~step_prev_reg;
  assign fall = ~step_sync & step_prev_reg;

  assign trigger = pol_reg ? fall : rise;

  assign dir_up = dir_sync ^ inv_reg;

  assign step_trigger_o = trigger;

  // apb decode; zero wait states
  assign pready_o   = 1'b1;
  assign setup      = psel_i & ~penable_i;
  assign wr_access  = psel_i & penable_i & pwrite_i;
  assign hit_ctrl   = (paddr_i == `MST_OFF_CTRL);
  assign hit_status = (paddr_i == `MST_OFF_STATUS);
  assign hit_coil   = (paddr_i == `MST_OFF_COIL);
  assign hit_any    = hit_ctrl | hit_status | hit_coil;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sel_reg <= `MST_RST_SEL;
      inv_reg <= 1'b0;
      pol_reg <= 1'b0;
    end else if (wr_access && hit_ctrl) begin
      sel_reg <= pwdata_i[`MST_CTRL_SEL_HI:`MST_CTRL_SEL_LO];
      inv_reg <= pwdata_i[`MST_CTRL_INV_BIT];
      pol_reg <= pwdata_i[`MST_CTRL_POL_BIT];
    end
  end

  // read data sampled in the setup cycle, held through the access
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= ~hit_any;
      if (!pwrite_i && hit_ctrl) begin
        prdata_o[`MST_CTRL_SEL_HI:`MST_CTRL_SEL_LO] <= sel_reg;
        prdata_o[`MST_CTRL_INV_BIT] <= inv_reg;
        prdata_o[`MST_CTRL_POL_BIT] <= pol_reg;
      end
      if (!pwrite_i && hit_status) begin
        prdata_o[6:0] <= pos_reg;
      end
      if (!pwrite_i && hit_coil) begin
        prdata_o[`MST_COIL_X_HI:`MST_COIL_X_LO] <= coil_x_o;
        prdata_o[`MST_COIL_Y_HI:`MST_COIL_Y_LO] <= coil_y_o;
      end
    end
  end

  // step size of the selected mode
  always @* begin
    case (sel_reg)
      `MST_SEL_32:      step_size = `MST_STEP_32;
      `MST_SEL_16:      step_size = `MST_STEP_16;
      `MST_SEL_8:       step_size = `MST_STEP_8;
      `MST_SEL_4:       step_size = `MST_STEP_4;
      `MST_SEL_2:       step_size = `MST_STEP_2;
      `MST_SEL_HALF_SQ: step_size = `MST_STEP_2;
      `MST_SEL_FULL:    step_size = `MST_STEP_FULL;
      default:          step_size = `MST_STEP_32;
    endcase
  end

  always @* begin
    if (dir_up) begin
      pos_next = pos_reg + step_size;
    end else begin
      pos_next = pos_reg - step_size;
    end
  end

  // stepping from the present position keeps any grid offset intact,
  // so no snap logic is needed when the resolution changes
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_reg <= `MST_RST_POS;
      act_reg <= `MST_RST_SEL;
    end else if (trigger) begin
      act_reg <= sel_reg;
      pos_reg <= pos_next;
    end
  end

  assign microstep_position_o = pos_reg;
  assign active_resolution_o  = act_reg;

  assign lo_addr = {1'b0, pos_reg[4:0]};
  assign hi_addr = `MST_QUARTER - lo_addr;
  assign addr_x  = pos_reg[5] ? hi_addr : lo_addr;
  assign addr_y  = pos_reg[5] ? lo_addr : hi_addr;

  mst_sine_rom u_rom (
    .clk_i    (clk_i),
    .addr_a_i (addr_x),
    .addr_b_i (addr_y),
    .data_a_o (mag_x),
    .data_b_o (mag_y)
  );

  // side data delayed to line up with the registered table
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      neg_x_reg  <= 1'b0;
      neg_y_reg  <= 1'b0;
      square_reg <= 1'b0;
    end else begin
      neg_x_reg  <= pos_reg[6];
      neg_y_reg  <= pos_reg[6] ^ pos_reg[5];
      square_reg <= (act_reg == `MST_SEL_HALF_SQ) || (act_reg == `MST_SEL_FULL);
    end
  end

  always @* begin
    out_x = mag_x;
    out_y = mag_y;
    if (square_reg) begin
      out_x = (mag_x != `MST_ZERO_MAG) ? `MST_FULL_SCALE : `MST_ZERO_MAG;
      out_y = (mag_y != `MST_ZERO_MAG) ? `MST_FULL_SCALE : `MST_ZERO_MAG;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      coil_x_o <= `MST_RST_COIL;
      coil_y_o <= `MST_RST_COIL;
    end else begin
      coil_x_o <= neg_x_reg ? (~{1'b0, out_x} + 11'h001) : {1'b0, out_x};
      coil_y_o <= neg_y_reg ? (~{1'b0, out_y} + 11'h001) : {1'b0, out_y};
    end
  end

endmodule

`default_nettype wire
